// ===== logic/liu_pkg.sv
// Shared constants and types of the line interface system-side data port
package liu_pkg;

    // Core clock and line timing
    localparam int unsigned CORE_CLK_MHZ = 125;
    localparam int unsigned QTR_DIV_DEF = 1;
    localparam int unsigned DIV_W = 16;

    // Data path widths and FIFO depth
    localparam int unsigned NIB_W = 4;
    localparam int unsigned FIFO_DEPTH_DEF = 16;

    // Register byte offsets
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_STAT = 4'h4;

    // Control register fields
    localparam int unsigned CTRL_COAX_BIT = 0;
    localparam int unsigned CTRL_MODE_LSB = 1;
    localparam int unsigned CTRL_TXEN_BIT = 3;
    localparam int unsigned CTRL_INV_BIT = 4;

    // Status register fields
    localparam int unsigned STAT_LOS_BIT = 0;
    localparam int unsigned STAT_OVF_BIT = 1;
    localparam int unsigned STAT_UDF_BIT = 2;
    localparam int unsigned STAT_LVL_LSB = 8;

    // Transmit timing modes
    typedef enum logic [1:0] {
        TXM_MASTER = 2'b00,
        TXM_SLAVE = 2'b01,
        TXM_LOOP = 2'b10,
        TXM_SERIAL = 2'b11
    } liu_tx_mode_e;

    // Values after reset
    localparam logic COAX_SEL_RST = 1'b1;
    localparam logic TX_EN_RST = 1'b1;
    localparam logic CLK_INV_RST = 1'b0;
    localparam liu_tx_mode_e TX_MODE_RST = TXM_MASTER;

    // Quarter-bit phases and bit slots within a nibble
    // Receive samples sit half a bit late to cover the two-flop line synchroniser
    localparam logic [1:0] PH_SAMP_FIRST = 2'h2;
    localparam logic [1:0] PH_MID_PRE = 2'h1;
    localparam logic [1:0] PH_SAMP_SECOND = 2'h0;
    localparam logic [1:0] PH_LAST = 2'h3;
    localparam logic [1:0] BN_RISE_PRE = 2'h1;
    localparam logic [1:0] BN_LAST = 2'h3;

endpackage : liu_pkg

// ===== logic/liu_port.sv
// Line interface system-side data port: transmit FIFO, serialiser, COAX_MODE_SELECT/NRZ line and receive side
//
// How it works
// - Parallel nibbles captured on rising transmit clock by default, sent MSB first.
// - External parallel clock used only in slave and loop-timing parallel modes.
// - Parallel clock output driven only in master mode; it toggles during reset.
// - Serial mode samples data on rising edge of the serial input clock by default.
// - Coax outputs float when transmitter disabled; active during reset.
// - Line clock output runs at twice the bit rate, also during reset.
// - Optical output carries NRZ transmit data in fiber operation.
// - Receive nibbles hold the first received bit in the MSB.
// - Signal lost forces all parallel receive data low.
// - Parallel receive clock is the recovered clock divided by four, runs in reset.
// - Parallel receive data launched on the falling parallel clock edge.
// - Parallel receive clock keeps its phase and runs steadily while signal lost.
// - Signal lost forces serial receive data to zero.
// - Serial receive data launched on the falling serial clock edge.
// - Serial receive clock keeps its phase and runs steadily while signal lost.
// - Line input decoded as COAX_MODE_SELECT or NRZ by the line interface select.
// - Coax select resets to one; zero disables COAX_MODE_SELECT and uses optical output.
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module liu_fifo #(
    parameter int unsigned W = liu_pkg::NIB_W,
    parameter int unsigned DEPTH = liu_pkg::FIFO_DEPTH_DEF,
    localparam int unsigned AW = $clog2(DEPTH)
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o,
    output logic [AW:0] level_o
);
    import liu_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } liu_fifo_state_s;

    liu_fifo_state_s f_q;
    liu_fifo_state_s f_d;
    logic do_wr;
    logic do_rd;

    assign in_ready_o = f_q.cnt != (AW+1)'(DEPTH);
    assign out_valid_o = f_q.cnt != '0;
    assign out_data_o = f_q.mem[f_q.rp];
    assign level_o = f_q.cnt;
    assign do_wr = in_valid_i && in_ready_o;
    assign do_rd = out_ready_i && out_valid_o;

    always_comb begin
        f_d = f_q;
        if (do_wr) begin
            f_d.mem[f_q.wp] = in_data_i;
            f_d.wp = (f_q.wp == AW'(DEPTH - 1)) ? '0 : f_q.wp + 1'b1;
        end
        if (do_rd) begin
            f_d.rp = (f_q.rp == AW'(DEPTH - 1)) ? '0 : f_q.rp + 1'b1;
        end
        case ({do_wr, do_rd})
            2'b10: f_d.cnt = f_q.cnt + 1'b1;
            2'b01: f_d.cnt = f_q.cnt - 1'b1;
            default: f_d.cnt = f_q.cnt;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

endmodule : liu_fifo

////////////////////////////////////////////////////////////////////////////////
module liu_port #(
    parameter int unsigned QTR_DIV = liu_pkg::QTR_DIV_DEF,
    parameter int unsigned FIFO_DEPTH = liu_pkg::FIFO_DEPTH_DEF
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [liu_pkg::NIB_W-1:0] tx_nibble_i,
    input wire logic tx_par_clk_in_i,
    output logic tx_par_clk_out_o,
    output logic tx_par_clk_out_oe_o,
    input wire logic tx_ser_data_in_p_i,
    input wire logic tx_ser_clk_in_p_i,
    output logic tx_fifo_ready_o,
    output logic coax_line_out_p_o,
    output logic coax_line_out_oe_o,
    output logic line_clk_out_p_o,
    output logic optical_data_out_p_o,
    input wire logic line_in_p_i,
    input wire logic signal_lost_i,
    output logic [liu_pkg::NIB_W-1:0] rx_nibble_o,
    output logic rx_par_clk_out_o,
    output logic rx_ser_data_out_p_o,
    output logic rx_ser_clk_out_p_o
);
    import liu_pkg::*;

    localparam int unsigned LVL_W = $clog2(FIFO_DEPTH) + 1;

    // Clock generator: two-state so it runs free, reset or not
    typedef struct packed {
        bit [DIV_W-1:0] div;
        bit [1:0] ph;
        bit [1:0] bn;
        bit line_clk;
        bit rser_clk;
        bit rpar_clk;
        bit tpar_clk;
    } liu_clkgen_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic coax_sel;
        liu_tx_mode_e mode;
        logic tx_en;
        logic clk_inv;
        logic ovf;
        logic udf;
        logic [2:0] pclk_s;
        logic [2:0] sclk_s;
        logic [1:0] sdat_s;
        logic [1:0] line_s;
        logic [1:0] los_s;
        logic [NIB_W-1:0] nib_s1;
        logic [NIB_W-1:0] nib_s2;
        logic [NIB_W-1:0] gsh;
        logic [1:0] gcnt;
        logic push_v;
        logic [NIB_W-1:0] push_d;
        logic [NIB_W-1:0] tsh;
        logic tbit;
        logic cmi_lvl;
        logic coax_out;
        logic coax_oe;
        logic opt_out;
        logic tpar_oe;
        logic fifo_rdy;
        logic cmi_first;
        logic rbit;
        logic [NIB_W-1:0] rsh;
        logic rser;
        logic [NIB_W-1:0] rnib;
    } liu_port_state_s;

    localparam liu_port_state_s RST_STATE = '{
        coax_sel: COAX_SEL_RST, mode: TX_MODE_RST, tx_en: TX_EN_RST,
        clk_inv: CLK_INV_RST, coax_oe: 1'b1, tpar_oe: 1'b1, default: '0};

    liu_clkgen_s ck_q;
    liu_clkgen_s ck_d;
    liu_port_state_s s_q;
    liu_port_state_s s_d;

    logic qtick;
    logic bit_start;
    logic nib_start;
    logic mid_tick;
    logic master_edge;
    logic ext_edge;
    logic ser_edge;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [NIB_W-1:0] fifo_out_data;
    logic [LVL_W-1:0] fifo_level;
    logic bus_req;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;

    ////////////////////////////////////////////////////////////////////////////
    // Line timing: quarter-bit ticks, bit and nibble slots
    assign qtick = ck_q.div == DIV_W'(QTR_DIV - 1);
    assign bit_start = qtick && (ck_q.ph == PH_LAST);
    assign nib_start = bit_start && (ck_q.bn == BN_LAST);
    assign mid_tick = qtick && (ck_q.ph == PH_MID_PRE);

    always_comb begin
        ck_d = ck_q;
        ck_d.div = qtick ? '0 : ck_q.div + 1'b1;
        if (qtick) begin
            ck_d.ph = ck_q.ph + 1'b1;
            ck_d.line_clk = !ck_q.line_clk;
        end
        if (bit_start) begin
            ck_d.bn = ck_q.bn + 1'b1;
        end
        // Divided clocks never stop; signal loss leaves their phase alone
        ck_d.rser_clk = ck_d.ph[1];
        ck_d.rpar_clk = ck_d.bn[1];
        ck_d.tpar_clk = ck_d.bn[1];
    end

    always_ff @(posedge core_clk_i) begin
        ck_q <= ck_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit FIFO between framer capture and the line serialiser
    liu_fifo #(
        .W(NIB_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_valid_i(s_q.push_v),
        .in_ready_o(fifo_in_ready),
        .in_data_i(s_q.push_d),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out_data),
        .level_o(fifo_level)
    );

    assign fifo_pop = nib_start && fifo_out_valid;

    ////////////////////////////////////////////////////////////////////////////
    // Register words and edge detection on synchronised pins
    assign bus_req = wb_cyc_i && wb_stb_i && !s_q.ack;
    assign master_edge = s_q.clk_inv ? nib_start : (bit_start && ck_q.bn == BN_RISE_PRE);
    assign ext_edge = s_q.clk_inv ? (!s_q.pclk_s[1] && s_q.pclk_s[2])
                                  : (s_q.pclk_s[1] && !s_q.pclk_s[2]);
    assign ser_edge = s_q.clk_inv ? (!s_q.sclk_s[1] && s_q.sclk_s[2])
                                  : (s_q.sclk_s[1] && !s_q.sclk_s[2]);

    always_comb begin
        ctrl_word = '0;
        ctrl_word[CTRL_COAX_BIT] = s_q.coax_sel;
        ctrl_word[CTRL_MODE_LSB +: 2] = s_q.mode;
        ctrl_word[CTRL_TXEN_BIT] = s_q.tx_en;
        ctrl_word[CTRL_INV_BIT] = s_q.clk_inv;
        stat_word = '0;
        stat_word[STAT_LOS_BIT] = s_q.los_s[1];
        stat_word[STAT_OVF_BIT] = s_q.ovf;
        stat_word[STAT_UDF_BIT] = s_q.udf;
        stat_word[STAT_LVL_LSB +: LVL_W] = fifo_level;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main state update
    always_comb begin
        logic [NIB_W-1:0] nb;
        logic clr;
        nb = '0;
        clr = 1'b0;
        s_d = s_q;

        // Bus slave: one wait state, unmapped reads return zero
        s_d.ack = bus_req;
        s_d.rdat = '0;
        if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                ADR_CTRL: s_d.rdat = ctrl_word;
                ADR_STAT: s_d.rdat = stat_word;
                default: s_d.rdat = '0;
            endcase
        end
        if (bus_req && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                ADR_CTRL: begin
                    s_d.coax_sel = wb_dat_i[CTRL_COAX_BIT];
                    s_d.mode = liu_tx_mode_e'(wb_dat_i[CTRL_MODE_LSB +: 2]);
                    s_d.tx_en = wb_dat_i[CTRL_TXEN_BIT];
                    s_d.clk_inv = wb_dat_i[CTRL_INV_BIT];
                end
                ADR_STAT: clr = 1'b1;
                default: clr = 1'b0;
            endcase
        end

        // Two-stage synchronisers, clocks get a third stage for edges
        s_d.pclk_s = {s_q.pclk_s[1:0], tx_par_clk_in_i};
        s_d.sclk_s = {s_q.sclk_s[1:0], tx_ser_clk_in_p_i};
        s_d.sdat_s = {s_q.sdat_s[0], tx_ser_data_in_p_i};
        s_d.line_s = {s_q.line_s[0], line_in_p_i};
        s_d.los_s = {s_q.los_s[0], signal_lost_i};
        s_d.nib_s1 = tx_nibble_i;
        s_d.nib_s2 = s_q.nib_s1;

        // Capture from the framer
        s_d.push_v = 1'b0;
        case (s_q.mode)
            TXM_MASTER: begin
                if (master_edge) begin
                    s_d.push_v = 1'b1;
                    s_d.push_d = s_q.nib_s2;
                end
            end
            TXM_SLAVE, TXM_LOOP: begin
                if (ext_edge) begin
                    s_d.push_v = 1'b1;
                    s_d.push_d = s_q.nib_s2;
                end
            end
            TXM_SERIAL: begin
                if (ser_edge) begin
                    s_d.gsh = {s_q.gsh[NIB_W-2:0], s_q.sdat_s[1]};
                    s_d.gcnt = s_q.gcnt + 1'b1;
                    if (s_q.gcnt == BN_LAST) begin
                        s_d.push_v = 1'b1;
                        s_d.push_d = {s_q.gsh[NIB_W-2:0], s_q.sdat_s[1]};
                    end
                end
            end
            default: s_d.push_v = 1'b0;
        endcase

        // Sticky errors: write one clears, a new event wins
        s_d.ovf = (s_q.ovf && !(clr && wb_dat_i[STAT_OVF_BIT]))
                  || (s_q.push_v && !fifo_in_ready);
        s_d.udf = (s_q.udf && !(clr && wb_dat_i[STAT_UDF_BIT]))
                  || (nib_start && !fifo_out_valid);
        s_d.fifo_rdy = fifo_in_ready;

        // Serialiser and line encoder; an empty FIFO sends zeros
        if (bit_start) begin
            nb = nib_start ? (fifo_out_valid ? fifo_out_data : '0) : s_q.tsh;
            s_d.tbit = nb[NIB_W-1];
            s_d.tsh = {nb[NIB_W-2:0], 1'b0};
            if (nb[NIB_W-1]) begin
                s_d.cmi_lvl = !s_q.cmi_lvl;
                s_d.coax_out = !s_q.cmi_lvl;
            end else begin
                s_d.coax_out = 1'b0;
            end
            s_d.opt_out = s_q.coax_sel ? 1'b0 : nb[NIB_W-1];
        end else if (mid_tick && !s_q.tbit) begin
            s_d.coax_out = 1'b1;
        end
        s_d.coax_oe = s_q.tx_en && s_q.coax_sel;
        s_d.tpar_oe = s_q.mode == TXM_MASTER;

        // Receive decode: COAX_MODE_SELECT compares the two half-bits, NRZ samples mid-bit
        if (qtick && ck_q.ph == PH_SAMP_FIRST) begin
            s_d.cmi_first = s_q.line_s[1];
        end
        if (qtick && ck_q.ph == PH_SAMP_SECOND) begin
            s_d.rbit = s_q.coax_sel ? (s_q.cmi_first == s_q.line_s[1]) : s_q.line_s[1];
        end
        if (bit_start) begin
            s_d.rser = s_q.rbit;
            s_d.rsh = {s_q.rsh[NIB_W-2:0], s_q.rbit};
            if (ck_q.bn == BN_LAST) begin
                s_d.rnib = {s_q.rsh[NIB_W-2:0], s_q.rbit};
            end
        end
        if (s_q.los_s[1]) begin
            s_d.rser = 1'b0;
            s_d.rnib = '0;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdat;
    assign tx_par_clk_out_o = ck_q.tpar_clk;
    assign tx_par_clk_out_oe_o = s_q.tpar_oe;
    assign tx_fifo_ready_o = s_q.fifo_rdy;
    assign coax_line_out_p_o = s_q.coax_out;
    assign coax_line_out_oe_o = s_q.coax_oe;
    assign line_clk_out_p_o = ck_q.line_clk;
    assign optical_data_out_p_o = s_q.opt_out;
    assign rx_nibble_o = s_q.rnib;
    assign rx_par_clk_out_o = ck_q.rpar_clk;
    assign rx_ser_data_out_p_o = s_q.rser;
    assign rx_ser_clk_out_p_o = ck_q.rser_clk;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    logic los_q;
    logic pop_msb;
    logic [DIV_W-1:0] per_cnt;
    logic per_seen;

    assign los_q = s_q.los_s[1];
    assign pop_msb = fifo_out_data[NIB_W-1];

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            per_cnt <= '0;
            per_seen <= 1'b0;
        end else if (ck_d.rpar_clk && !ck_q.rpar_clk) begin
            per_cnt <= '0;
            per_seen <= 1'b1;
        end else begin
            per_cnt <= per_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    chk_par_oe_master: assert property (
        (s_q.mode == TXM_MASTER) |=> tx_par_clk_out_oe_o)
        else $error("parallel clock output not enabled in master mode");
    chk_par_oe_other: assert property (
        (s_q.mode != TXM_MASTER) |=> !tx_par_clk_out_oe_o)
        else $error("parallel clock output enabled outside master mode");
    chk_ext_clk_unused: assert property (
        (s_q.mode == TXM_MASTER && !master_edge) |=> !s_q.push_v)
        else $error("capture without internal clock edge in master mode");
    chk_serial_capture: assert property (
        (s_q.mode == TXM_SERIAL && !ser_edge) |=> !s_q.push_v)
        else $error("serial capture without serial clock edge");
    chk_coax_float: assert property (
        !s_q.tx_en |=> !coax_line_out_oe_o)
        else $error("coax output driven while transmitter disabled");
    chk_line_clk_run: assert property (
        qtick |=> (line_clk_out_p_o != $past(line_clk_out_p_o)))
        else $error("line clock did not toggle on quarter tick");
    chk_optical_quiet: assert property (
        (s_q.coax_sel && bit_start) |=> !optical_data_out_p_o)
        else $error("optical output active in coax mode");
    chk_msb_first: assert property (
        fifo_pop |=> (s_q.tbit == $past(pop_msb)))
        else $error("nibble MSB not sent first");
    chk_los_nibble: assert property (
        los_q |=> (rx_nibble_o == '0))
        else $error("receive nibble not low during signal loss");
    chk_los_serial: assert property (
        los_q |=> !rx_ser_data_out_p_o)
        else $error("serial receive data not zero during signal loss");
    chk_rx_par_fall: assert property (
        (!$past(los_q) && $changed(rx_nibble_o)) |-> $fell(rx_par_clk_out_o))
        else $error("receive nibble changed off the falling clock edge");
    chk_rx_ser_fall: assert property (
        (!$past(los_q) && $changed(rx_ser_data_out_p_o)) |-> $fell(rx_ser_clk_out_p_o))
        else $error("serial receive data changed off the falling clock edge");
    chk_nibble_period: assert property (
        (ck_d.rpar_clk && !ck_q.rpar_clk && per_seen)
        |-> (per_cnt == DIV_W'(16 * QTR_DIV - 1)))
        else $error("parallel clock period is not four bit times");
    chk_wb_ack_once: assert property (
        s_q.ack |=> !s_q.ack)
        else $error("bus acknowledge longer than one cycle");

    cov_serial_pop: cover property (fifo_pop && s_q.mode == TXM_SERIAL);
    cov_slave_push: cover property (s_q.push_v && s_q.mode == TXM_SLAVE);
    cov_overflow: cover property ($rose(s_q.ovf));
    cov_los_entry: cover property ($rose(los_q));

endmodule : liu_port

// ===== test/liu_framer_model.sv
// Behavioural framer that feeds the transmit side of the port
`timescale 1ns/1ps

module liu_framer_model (
    input wire logic core_clk_i,
    input wire logic [1:0] rate_i,
    input wire logic [3:0] nib_i,
    output logic tx_par_clk_in_o,
    output logic [3:0] tx_nibble_o,
    output logic tx_ser_clk_o,
    output logic tx_ser_data_o
);
    int cnt = 0;
    int scnt = 0;
    logic [1:0] bi = 2'h3;

    initial begin
        tx_par_clk_in_o = 1'b0;
        tx_nibble_o = 4'h0;
        tx_ser_clk_o = 1'b0;
        tx_ser_data_o = 1'b0;
    end

    // Rate 0 stops the clocks and lets the idle data wander
    always @(posedge core_clk_i) begin
        if (rate_i == 2'h0) begin
            cnt <= 0;
            tx_nibble_o <= ~tx_nibble_o;
            tx_ser_data_o <= ~tx_ser_data_o;
        end else begin
            // One nibble per clock period; rate 2 overruns on purpose
            if (cnt >= ((rate_i == 2'h2) ? 1 : 15)) begin
                cnt <= 0;
                tx_par_clk_in_o <= ~tx_par_clk_in_o;
                if (tx_par_clk_in_o) begin
                    tx_nibble_o <= nib_i;
                end
            end else begin
                cnt <= cnt + 1;
            end
            // Serial data changes on the falling clock, MSB first
            if (scnt >= 3) begin
                scnt <= 0;
                tx_ser_clk_o <= ~tx_ser_clk_o;
                if (tx_ser_clk_o) begin
                    tx_ser_data_o <= nib_i[bi];
                    bi <= bi - 2'h1;
                end
            end else begin
                scnt <= scnt + 1;
            end
        end
    end
endmodule : liu_framer_model

// ===== test/tb.sv
// Register-driven bench for the system-side data port with looped-back line
`timescale 1ns/1ps

module tb;
    import liu_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we_r = 1'b0, lost = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, v;
    logic [1:0] rate = 2'h1;
    logic ack, pco, pcoe, fifo_rdy, cx, cxoe, lck, opt, rpc, rsd, rsc, pci, sck, sdt;
    logic lcp = 1'b0, rpp = 1'b0, rsp = 1'b0, tpp = 1'b0;
    logic [3:0] nib, rnib;
    int err_total = 0, comparisons = 0, nlc = 0, npc = 0, nsc = 0, ntc = 0, a0, a1, a2, a3, n;
    wire logic line_in = cxoe ? cx : opt;

    always #4 clk = ~clk;

    liu_framer_model fm (.core_clk_i(clk), .rate_i(rate), .nib_i(4'h7),
        .tx_par_clk_in_o(pci), .tx_nibble_o(nib), .tx_ser_clk_o(sck), .tx_ser_data_o(sdt));

    liu_port #(.QTR_DIV(2), .FIFO_DEPTH(16)) dut (.core_clk_i(clk), .rst_i(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we_r), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_nibble_i(nib),
        .tx_par_clk_in_i(pci), .tx_par_clk_out_o(pco), .tx_par_clk_out_oe_o(pcoe),
        .tx_ser_data_in_p_i(sdt), .tx_ser_clk_in_p_i(sck), .tx_fifo_ready_o(fifo_rdy),
        .coax_line_out_p_o(cx), .coax_line_out_oe_o(cxoe), .line_clk_out_p_o(lck),
        .optical_data_out_p_o(opt), .line_in_p_i(line_in), .signal_lost_i(lost),
        .rx_nibble_o(rnib), .rx_par_clk_out_o(rpc), .rx_ser_data_out_p_o(rsd),
        .rx_ser_clk_out_p_o(rsc));

    // Toggle counters of the free-running clock outputs
    always @(posedge clk) begin
        lcp <= lck;
        rpp <= rpc;
        rsp <= rsc;
        tpp <= pco;
        if (lck !== lcp) nlc <= nlc + 1;
        if (rpc !== rpp) npc <= npc + 1;
        if (rsc !== rsp) nsc <= nsc + 1;
        if (pco !== tpp) ntc <= ntc + 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    task complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we_r <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        v = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            err_total++;
            complete_run();
        end
    endtask : wb

    task clocks(input int ep);
        a0 = nlc;
        a1 = npc;
        a2 = nsc;
        a3 = ntc;
        repeat (64) @(negedge clk);
        chk("tx par clk toggles", ep, ntc - a3);
        chk("line clk toggles", 32, nlc - a0);
        chk("rx par clk toggles", ep, npc - a1);
        chk("rx ser clk toggles", 16, nsc - a2);
    endtask : clocks

    task loop_chk(input logic [31:0] ctrl, input string nm);
        wb(1'b1, ADR_CTRL, ctrl);
        repeat (400) @(negedge clk);
        chk(nm, 1, {31'h0, rnib inside {4'h7, 4'he, 4'hd, 4'hb}});
        $display("test %s done", nm);
    endtask : loop_chk

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        err_total++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge clk);
        chk("line clk in reset", 1, {31'h0, nlc > 0});
        rst <= 1'b0;
        wb(1'b0, ADR_CTRL, 32'h0);
        chk("ctrl reset", 32'h9, v);
        wb(1'b0, 4'h8, 32'h0);
        chk("unmapped read", 32'h0, v);
        chk("fifo ready", 1, {31'h0, fifo_rdy});
        chk("par clk oe master", 1, {31'h0, pcoe});
        $display("test reset done");
        loop_chk(32'h9, "coax loop");
        loop_chk(32'h8, "optical loop");
        chk("coax oe fiber", 0, {31'h0, cxoe});
        loop_chk(32'he, "serial loop");
        loop_chk(32'h1d, "loop timing inverted");
        wb(1'b1, ADR_CTRL, 32'h1);
        repeat (4) @(negedge clk);
        chk("coax oe tx off", 0, {31'h0, cxoe});
        wb(1'b1, ADR_CTRL, 32'hb);
        repeat (4) @(negedge clk);
        chk("par clk oe slave", 0, {31'h0, pcoe});
        clocks(4);
        @(posedge clk);
        lost <= 1'b1;
        repeat (10) @(negedge clk);
        clocks(4);
        chk("rx nibble lost", 0, {28'h0, rnib});
        chk("rx ser data lost", 0, {31'h0, rsd});
        wb(1'b0, ADR_STAT, 32'h0);
        chk("stat lost", 1, {31'h0, v[STAT_LOS_BIT]});
        lost <= 1'b0;
        $display("test clocks done");
        wb(1'b1, ADR_CTRL, 32'h9);
        wb(1'b1, ADR_STAT, 32'h6);
        rate <= 2'h2;
        repeat (200) @(negedge clk);
        wb(1'b0, ADR_STAT, 32'h0);
        chk("overflow master", 0, {31'h0, v[STAT_OVF_BIT]});
        wb(1'b1, ADR_CTRL, 32'hb);
        n = 0;
        // Wait for a refill just after a pop, so no pop falls before the status read
        for (int j = 0; j < 3; j++) begin
            while (fifo_rdy !== j[0] && n < 400) begin
                @(negedge clk);
                n++;
            end
        end
        chk("fifo full", 0, {31'h0, fifo_rdy});
        wb(1'b0, ADR_STAT, 32'h0);
        chk("overflow slave", 1, {31'h0, v[STAT_OVF_BIT]});
        chk("level full", 32'h10, {27'h0, v[12:8]});
        rate <= 2'h0;
        n = 0;
        do begin
            wb(1'b0, ADR_STAT, 32'h0);
            n++;
        end while (v[12:8] !== 5'h0 && n < 400);
        chk("level empty", 0, {27'h0, v[12:8]});
        // Underrun is flagged only at the next nibble start with the FIFO empty
        repeat (40) @(negedge clk);
        wb(1'b0, ADR_STAT, 32'h0);
        chk("underrun", 1, {31'h0, v[STAT_UDF_BIT]});
        wb(1'b1, ADR_STAT, 32'h2);
        wb(1'b0, ADR_STAT, 32'h0);
        chk("overflow cleared", 0, {31'h0, v[STAT_OVF_BIT]});
        $display("test fifo done");
        complete_run();
    end
endmodule : tb
